/* File: hw/lpc_pkg.sv */
// Purpose: Shared constants for the LIN physical-layer control block
// Assumes: One 8-bit register, byte-wide die-to-die access
// Notes:   Bit positions and bases as laid out in the control register
`default_nettype none
package lpc_pkg;
  // ***************************************
  // Address map
  // ***************************************
  localparam logic [15:0] LPC_BASE_BLOCKING    = 16'h0200;
  localparam logic [15:0] LPC_BASE_NONBLOCKING = 16'h0300;
  localparam logic [7:0]  LPC_CTRL_OFFSET      = 8'h18;
  localparam logic [15:0] LPC_ADDR_BLOCKING    = LPC_BASE_BLOCKING + 16'(LPC_CTRL_OFFSET);
  localparam logic [15:0] LPC_ADDR_NONBLOCKING = LPC_BASE_NONBLOCKING + 16'(LPC_CTRL_OFFSET);
  localparam logic [7:0]  LPC_CTRL_RESET       = 8'h00;

  // ***************************************
  // Field positions
  // ***************************************
  localparam int LPC_BIT_OT_IRQ_EN  = 7;
  localparam int LPC_BIT_OT_PRESENT = 6;
  localparam int LPC_BIT_RX_LEVEL   = 5;
  localparam int LPC_BIT_TX_FORCE   = 4;
  localparam int LPC_BIT_LOW_VOLTAGE_SHUTDOWN_DISABLE_DIS   = 3;
  localparam int LPC_BIT_ENABLE     = 2;
  localparam int LPC_BIT_SLEW_HI    = 1;
  localparam int LPC_BIT_SLEW_LO    = 0;

  // ***************************************
  // Slew-rate codes
  // ***************************************
  localparam logic [1:0] LPC_SLEW_NORMAL  = 2'h0;
  localparam logic [1:0] LPC_SLEW_SLOW    = 2'h1;
  localparam logic [1:0] LPC_SLEW_FAST    = 2'h2;
  localparam logic [1:0] LPC_SLEW_NORMAL2 = 2'h3;

  // Park state for the undervoltage handling
  typedef enum logic [1:0] {
    LPC_RUN,
    LPC_WAIT_REC,
    LPC_PARKED,
    LPC_RESUME
  } lpc_park_e;
endpackage
`default_nettype wire

/* File: hw/lpc_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous indications
// Assumes: Inputs are quasi-static levels from the analog side
// Notes:   First stage feeds only the second stage
`default_nettype none
module lpc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: hw/lpc_top.sv */
// Purpose: Control and status logic of the LIN physical-layer transceiver
// Assumes: Byte register port with read/write strobes on clk; analog pins async
// Notes:   Driver output is active high for dominant
//
// Contract
// - Undervoltage while recessive keeps driver recessive while it persists.
// - Undervoltage while dominant: finish dominant phase, then hold recessive.
// - After undervoltage, resume if transmit recessive, else at next rising edge.
// - Shutdown-disable bit 3 set ignores undervoltage; clear enables parking.
// - One 8-bit register at 0x18 from 0x0200 and 0x300, reset zero.
// - Bit 6 reads overtemperature present; reading clears the pending flag.
// - Bit 5 reads 0 when bus dominant, 1 when recessive.
// - Bit 4 set forces transmitter dominant, ORed with normal path.
// - Bit 2 enables transceiver; disabled after reset.
// - Slew field 00/11 normal, 01 slow, 10 fast.
// - Enabled overtemperature raises request; new one only after vanish and recur.
// - After overtemperature ends and transmit high, transmitter re-enables itself.
`default_nettype none
module lpc_top (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // Serial interface side
  input  wire logic       sci_txd,
  output logic            sci_rxd,
  // Analog side
  input  wire logic       bus_rx_level,
  input  wire logic       supply_undervoltage,
  input  wire logic       overtemp_in,
  output logic            driver_dominant,
  output logic            transceiver_enable,
  output logic [1:0]      slew_rate_select,
  output logic            slew_slow,
  output logic            slew_fast,
  output logic            overtemp_irq
);
  // ***************************************
  // Synchronisers
  // ***************************************
  logic [2:0] async_in;
  logic [2:0] async_s;
  logic       uv_s;
  logic       ot_s;
  logic       rx_s;

  assign async_in = {bus_rx_level, overtemp_in, supply_undervoltage};

  lpc_sync #(.WIDTH(3)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (async_in),
    .q   (async_s)
  );

  assign uv_s = async_s[0];
  assign ot_s = async_s[1];
  assign rx_s = async_s[2];

  // ***************************************
  // Register file
  // ***************************************
  logic       ot_irq_enable_r;
  logic       tx_force_r;
  logic       low_voltage_shutdown_disable_disable_r;
  logic       enable_r;
  logic [1:0] slew_r;
  logic       ot_flag_r;
  logic       ot_prev_r;
  logic [7:0] rdata_r;
  logic       wr_hit;
  logic       rd_hit;
  logic       ot_rise;
  logic       ot_flag_nxt;
  logic [7:0] status_word;

  assign reg_hit = (reg_addr == lpc_pkg::LPC_ADDR_BLOCKING) ||
                   (reg_addr == lpc_pkg::LPC_ADDR_NONBLOCKING);
  assign wr_hit  = ce && reg_wr && reg_hit;
  assign rd_hit  = ce && reg_rd && reg_hit;

  assign status_word = {ot_irq_enable_r, ot_s, rx_s, tx_force_r,
                        low_voltage_shutdown_disable_disable_r, enable_r, slew_r};

  always_ff @(posedge clk) begin
    if (rst) begin
      ot_irq_enable_r <= 1'b0;
      tx_force_r      <= 1'b0;
      low_voltage_shutdown_disable_disable_r  <= 1'b0;
      enable_r        <= 1'b0;
      slew_r          <= lpc_pkg::LPC_SLEW_NORMAL;
    end else if (wr_hit) begin
      ot_irq_enable_r <= reg_wdata[lpc_pkg::LPC_BIT_OT_IRQ_EN];
      tx_force_r      <= reg_wdata[lpc_pkg::LPC_BIT_TX_FORCE];
      low_voltage_shutdown_disable_disable_r  <= reg_wdata[lpc_pkg::LPC_BIT_LOW_VOLTAGE_SHUTDOWN_DISABLE_DIS];
      enable_r        <= reg_wdata[lpc_pkg::LPC_BIT_ENABLE];
      slew_r          <= reg_wdata[lpc_pkg::LPC_BIT_SLEW_HI:lpc_pkg::LPC_BIT_SLEW_LO];
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= lpc_pkg::LPC_CTRL_RESET;
    end else if (ce && reg_rd) begin
      rdata_r <= reg_hit ? status_word : 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // ***************************************
  // Overtemperature event flag
  // ***************************************
  // Edge only, so a lasting condition gives one request per occurrence
  assign ot_rise     = ot_s && !ot_prev_r;
  // A new edge in the same cycle as the acknowledging read wins
  assign ot_flag_nxt = ot_rise ? 1'b1 : (rd_hit ? 1'b0 : ot_flag_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      ot_prev_r <= 1'b0;
      ot_flag_r <= 1'b0;
    end else if (ce) begin
      ot_prev_r <= ot_s;
      ot_flag_r <= ot_flag_nxt;
    end
  end

  assign overtemp_irq = ot_flag_r && ot_irq_enable_r;

  // ***************************************
  // Overtemperature shutdown latch
  // ***************************************
  logic ot_shut_r;
  logic ot_shut_nxt;

  // Released only once the condition is gone and transmit input is high
  assign ot_shut_nxt = ot_s ? 1'b1 : (sci_txd ? 1'b0 : ot_shut_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      ot_shut_r <= 1'b0;
    end else if (ce) begin
      ot_shut_r <= ot_shut_nxt;
    end
  end

  // ***************************************
  // Undervoltage parking
  // ***************************************
  lpc_pkg::lpc_park_e park_r;
  lpc_pkg::lpc_park_e park_nxt;
  logic               tx_prev_r;
  logic               tx_dom_req;
  logic               tx_rise;
  logic               uv_active;
  logic               uv_dom;
  logic               parked;
  logic               drv_r;

  // sci_txd comes from logic on clk, so it is used unsynchronised
  assign tx_dom_req = !sci_txd || tx_force_r;
  assign tx_rise    = !tx_dom_req && tx_prev_r;
  assign uv_active  = uv_s && !low_voltage_shutdown_disable_disable_r;
  // Judged on the real driver, so a disabled or cut driver counts as recessive
  assign uv_dom     = drv_r && tx_dom_req;

  always_comb begin
    park_nxt = park_r;
    case (park_r)
      lpc_pkg::LPC_RUN: begin
        if (uv_active) begin
          park_nxt = uv_dom ? lpc_pkg::LPC_WAIT_REC : lpc_pkg::LPC_PARKED;
        end
      end
      lpc_pkg::LPC_WAIT_REC: begin
        if (!uv_active) begin
          park_nxt = lpc_pkg::LPC_RUN;
        end else if (!tx_dom_req || !drv_r) begin
          park_nxt = lpc_pkg::LPC_PARKED;
        end
      end
      lpc_pkg::LPC_PARKED: begin
        if (!uv_active) begin
          park_nxt = tx_dom_req ? lpc_pkg::LPC_RESUME : lpc_pkg::LPC_RUN;
        end
      end
      lpc_pkg::LPC_RESUME: begin
        if (uv_active) begin
          park_nxt = lpc_pkg::LPC_PARKED;
        end else if (tx_rise) begin
          park_nxt = lpc_pkg::LPC_RUN;
        end
      end
      default: park_nxt = lpc_pkg::LPC_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      park_r    <= lpc_pkg::LPC_RUN;
      tx_prev_r <= 1'b0;
    end else if (ce) begin
      park_r    <= park_nxt;
      tx_prev_r <= tx_dom_req;
    end
  end

  // A dominant phase under way keeps driving until transmit goes recessive
  assign parked = (park_r == lpc_pkg::LPC_PARKED) ||
                  (park_r == lpc_pkg::LPC_RESUME) ||
                  (park_r == lpc_pkg::LPC_WAIT_REC && !drv_r) ||
                  (park_r == lpc_pkg::LPC_RUN && uv_active && !uv_dom);

  // ***************************************
  // Driver outputs
  // ***************************************
  logic drv_nxt;
  logic rxd_r;

  assign drv_nxt = enable_r && !ot_s && !ot_shut_r && !parked && tx_dom_req;

  always_ff @(posedge clk) begin
    if (rst) begin
      drv_r <= 1'b0;
      rxd_r <= 1'b1;
    end else if (ce) begin
      drv_r <= drv_nxt;
      rxd_r <= enable_r ? rx_s : 1'b1;
    end
  end

  assign driver_dominant    = drv_r;
  assign sci_rxd            = rxd_r;
  assign transceiver_enable = enable_r;
  assign slew_rate_select   = slew_r;
  assign slew_slow          = (slew_r == lpc_pkg::LPC_SLEW_SLOW);
  assign slew_fast          = (slew_r == lpc_pkg::LPC_SLEW_FAST);
endmodule
`default_nettype wire

/* File: sim/lpc_props.sv */
// Purpose: Concurrent checks on the LIN transceiver control block
// Assumes: Control byte mirrored from register writes; sync latency two cycles
// Notes:   Repetition counts leave margin for the synchronisers
`default_nettype none
module lpc_props (
  // Clock and register port
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  // Link and analog side
  input wire logic       sci_txd,
  input wire logic       supply_undervoltage,
  input wire logic       overtemp_in,
  input wire logic       driver_dominant,
  input wire logic       transceiver_enable,
  input wire logic [1:0] slew_rate_select,
  input wire logic       overtemp_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_r;
  logic       dom_req;
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);
  // Mirror keeps the writable bits so checks need no read traffic
  always_ff @(posedge clk)
    if (rst) ctl_r <= 8'h00;
    else if (ce && reg_wr && reg_hit) ctl_r <= reg_wdata;
  assign dom_req = !sci_txd || ctl_r[4];
  chk_rst_clear: assert property ($fell(rst) |->
    reg_rdata == 8'h00 && !driver_dominant && !transceiver_enable) else $error("reset");
  chk_out_map: assert property (transceiver_enable == ctl_r[2] &&
    slew_rate_select == ctl_r[1:0]) else $error("control outputs");
  chk_rd_back: assert property (reg_rd && reg_hit && !reg_wr |=>
    reg_rdata[4:0] == ctl_r[4:0] && reg_rdata[7] == ctl_r[7]) else $error("read back");
  chk_rd_miss: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  chk_irq_gate: assert property (overtemp_irq |-> ctl_r[7])
    else $error("masked irq");
  chk_irq_ack: assert property ((!overtemp_in [*4] ##0 (reg_rd && reg_hit)) |=>
    !overtemp_irq) else $error("irq not acknowledged");
  chk_ot_off: assert property (overtemp_in [*4] |=> !driver_dominant)
    else $error("driver on in overtemperature");
  chk_uv_park: assert property ((!ctl_r[3] && supply_undervoltage) [*6] ##0
    !driver_dominant |=> !driver_dominant) else $error("park lost");
  chk_dom_hold: assert property ((ctl_r[2] && !overtemp_in && !sci_txd &&
    driver_dominant) [*4] |=> driver_dominant) else $error("dominant cut");
  chk_low_voltage_shutdown_disable_on: assert property ((ctl_r[3] && ctl_r[2] && !overtemp_in && sci_txd) [*4]
    ##1 (ctl_r[3] && ctl_r[2] && !overtemp_in) |=> driver_dominant == $past(dom_req))
    else $error("driver ignores request");
  cov_park: cover property (supply_undervoltage && $fell(driver_dominant));
  cov_irq: cover property ($rose(overtemp_irq));
  cov_force: cover property (ctl_r[4] && sci_txd && driver_dominant);
endmodule
bind lpc_top lpc_props i_props (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .sci_txd(sci_txd), .supply_undervoltage(supply_undervoltage), .overtemp_in(overtemp_in),
  .driver_dominant(driver_dominant), .transceiver_enable(transceiver_enable),
  .slew_rate_select(slew_rate_select), .overtemp_irq(overtemp_irq));
`default_nettype wire

/* File: sim/lpc_bus_model.sv */
// Purpose: LIN wire with pull-up and one other node
// Assumes: Wire is recessive unless a node pulls it low
// Notes:   Slow mode adds one cycle of wire delay
`default_nettype none
module lpc_bus_model (
  // Clock and mode
  input  wire logic clk,
  input  wire logic slow,
  // Wire
  input  wire logic drv_dom,
  input  wire logic ext_dom,
  output logic      rx_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wire_now;
  logic lag_r;
  assign wire_now = !(drv_dom || ext_dom);
  always_ff @(posedge clk) lag_r <= wire_now;
  assign rx_level = slow ? lag_r : wire_now;
endmodule
`default_nettype wire

/* File: sim/lin_phy_control_tb.sv */
// Purpose: Self-checking bench for the LIN transceiver control block
// Assumes: Inputs change on the falling edge; ce held high
// Notes:   Reads are queued and compared by a monitor
`default_nettype none
module lin_phy_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] a_blk = lpc_pkg::LPC_ADDR_BLOCKING;
  localparam logic [15:0] a_nb = lpc_pkg::LPC_ADDR_NONBLOCKING;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, txd = 1, uv = 0, ot = 0, ext = 0, slow = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, v, exp_q[$];
  logic hit, rxd, rx, drv, en, sslow, sfast, irq, rd_d = 0;
  logic [1:0] slew;
  int err_total = 0, n_checks = 0;
  always #2 clk = ~clk;
  lpc_top i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .sci_txd(txd), .sci_rxd(rxd),
    .bus_rx_level(rx), .supply_undervoltage(uv), .overtemp_in(ot), .driver_dominant(drv),
    .transceiver_enable(en), .slew_rate_select(slew), .slew_slow(sslow), .slew_fast(sfast),
    .overtemp_irq(irq));
  lpc_bus_model i_bus (.clk(clk), .slow(slow), .drv_dom(drv), .ext_dom(ext), .rx_level(rx));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wrt(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1;
    exp_q.push_back(e);
    @(negedge clk);
    rd = 0;
  endtask
  // Set link inputs, wait n cycles, then check the driver
  task automatic st(input logic t, u, o, input int n, input logic e);
    txd = t;
    uv = u;
    ot = o;
    repeat (n) @(negedge clk);
    cmp({7'h00, drv}, {7'h00, e});
  endtask
  // Read data stands from the edge after the strobe, so look at the falling edge
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d) cmp(rdata, exp_q.pop_front());
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end
  initial begin
    void'($urandom(39));
    repeat (2) @(negedge clk);
    rst = 0;
    st(1, 0, 0, 4, 0);
    wrt(16'h0217, 8'hff);
    rdc(a_blk, 8'h20);
    rdc(a_nb, 8'h20);
    rdc(16'h0219, 8'h00);
    cmp({7'h00, en}, 8'h00);
    cmp({7'h00, hit}, 8'h00);
    ext = 1;
    st(1, 0, 0, 4, 0);
    cmp({7'h00, rxd}, 8'h01);
    rdc(a_blk, 8'h00);
    cmp({7'h00, hit}, 8'h01);
    ext = 0;
    $display("test map done");
    wrt(a_blk, 8'h04);
    st(0, 0, 0, 1, 1);
    st(0, 0, 0, 3, 1);
    cmp({7'h00, rxd}, 8'h00);
    rdc(a_nb, 8'h04);
    st(1, 1, 0, 4, 0);
    st(0, 1, 0, 4, 0);
    st(0, 0, 0, 4, 0);
    st(1, 0, 0, 2, 0);
    st(0, 0, 0, 1, 1);
    st(0, 1, 0, 4, 1);
    st(1, 1, 0, 1, 0);
    st(0, 1, 0, 4, 0);
    st(1, 0, 0, 4, 0);
    st(0, 0, 0, 1, 1);
    $display("test undervoltage done");
    wrt(a_blk, 8'h0c);
    st(1, 1, 0, 4, 0);
    st(0, 1, 0, 1, 1);
    st(1, 0, 0, 4, 0);
    wrt(a_nb, 8'h14);
    st(1, 0, 0, 4, 1);
    rdc(a_blk, 8'h14);
    $display("test force done");
    wrt(a_blk, 8'h84);
    st(0, 0, 1, 4, 0);
    cmp({7'h00, irq}, 8'h01);
    rdc(a_blk, 8'he4);
    st(0, 0, 1, 4, 0);
    cmp({7'h00, irq}, 8'h00);
    st(0, 0, 0, 4, 0);
    st(1, 0, 0, 2, 0);
    st(0, 0, 0, 1, 1);
    st(0, 0, 1, 4, 0);
    cmp({7'h00, irq}, 8'h01);
    wrt(a_nb, 8'h04);
    cmp({7'h00, irq}, 8'h00);
    st(1, 0, 0, 4, 0);
    $display("test overtemperature done");
    slow = 1;
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[1:0] = i[1:0];
      wrt(i[0] ? a_nb : a_blk, v);
      cmp({6'h00, sfast, sslow}, {6'h00, v[1:0] == 2'h2, v[1:0] == 2'h1});
      cmp({6'h00, slew}, {6'h00, v[1:0]});
      st(1, 0, 0, 4, v[2] & v[4]);
      rdc(i[0] ? a_blk : a_nb, {v[7], 1'b0, ~(v[2] & v[4]), v[4:0]});
    end
    $display("test random done");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    st(1, 0, 0, 2, 0);
    cmp({5'h00, rxd, irq, en}, 8'h04);
    rdc(a_nb, 8'h20);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
